// File: hdl/tca_defines.vh
`ifndef TCA_DEFINES_VH
`define TCA_DEFINES_VH

// counter and modulo geometry
`define TCA_CNT_W 16
`define TCA_BYTE_W 8
`define TCA_MOD_RESET 16'hffff
`define TCA_CNT_RESET 16'h0000

// prescaler: seven rates, divide by 2**select, select 7 folds onto 6
`define TCA_PS_W 3
`define TCA_PS_MAX 3'h6
`define TCA_DIV_W 6

// mode select pair (b:a)
`define TCA_MS_CAPTURE 2'h0
`define TCA_MS_COMPARE 2'h1

// edge/level select pair (b:a) in compare mode
`define TCA_ELS_NONE 2'h0
`define TCA_ELS_TOGGLE 2'h1
`define TCA_ELS_CLEAR 2'h2
`define TCA_ELS_SET 2'h3

// pin flops reset low, pins released
`define TCA_PIN_RESET 1'h0

`endif

// File: hdl/tca_prescale.v
`timescale 1ns/1ps
`include "tca_defines.vh"
module tca_prescale #(
	parameter DIV_W = `TCA_DIV_W
) (
	input wire ref_clk,
	input wire rst,
	input wire clear,
	input wire halt,
	input wire [2:0] prescale_select,
	output reg tick
);

reg [DIV_W-1:0] div_reg;
reg [DIV_W-1:0] mask;
reg [2:0] sel;

always @* begin
	sel = prescale_select;
	if (prescale_select > `TCA_PS_MAX) begin
		sel = `TCA_PS_MAX;
	end
	mask = ~({DIV_W{1'b1}} << sel);
end

////////////////////////////////////////////////////////////////////////////
// divider chain; tick marks the last bus cycle of each counter clock
always @(posedge ref_clk) begin
	if (rst || clear) begin // RL15
		div_reg <= {DIV_W{1'b0}};
		tick <= 1'b0;
	end else if (halt) begin // RL15
		tick <= 1'b0;
	end else begin
		div_reg <= div_reg + {{(DIV_W-1){1'b0}}, 1'b1};
		tick <= ((div_reg & mask) == mask); // RL4
	end
end

endmodule // tca_prescale

// File: hdl/tca_capture.v
`timescale 1ns/1ps
`include "tca_defines.vh"
module tca_capture #(
	parameter CNT_W = `TCA_CNT_W
) (
	input wire ref_clk,
	input wire rst,
	input wire pin_in,
	input wire capture_en,
	input wire rise_en,
	input wire fall_en,
	input wire [CNT_W-1:0] count,
	output reg cap_stb,
	output reg [CNT_W-1:0] cap_val
);

reg sync1_reg;
reg sync2_reg;
reg prev_reg;
wire rise;
wire fall;

assign rise = sync2_reg & ~prev_reg;
assign fall = ~sync2_reg & prev_reg;

////////////////////////////////////////////////////////////////////////////
// pin synchroniser, then edge qualification
always @(posedge ref_clk) begin
	// chain shifts through reset, so a pulled-up pin gives no false edge
	// limitation: reset must last three cycles for the chain to settle
	sync1_reg <= pin_in;
	sync2_reg <= sync1_reg;
	prev_reg <= sync2_reg;
	if (rst) begin
		cap_stb <= 1'b0;
	end else begin
		cap_stb <= capture_en & ((rise & rise_en) | (fall & fall_en)); // RL5
	end
end

// latched every qualifying edge; not reset so old captures survive
always @(posedge ref_clk) begin
	if (capture_en & ((rise & rise_en) | (fall & fall_en))) begin // RL7
		cap_val <= count; // RL6
	end
end

endmodule // tca_capture

// File: hdl/tca_timer.v
// Contract
// RL1: 16-bit up-counter, free running or wrapping at modulo high/low value.
// RL2: counter readable anytime without disturbing counting.
// RL3: each of two channels separately input capture or output compare.
// RL4: prescaler from bus clock, seven rates, 3-bit select field.
// RL5: capture triggers on rising, falling or both edges via two bits.
// RL6: active capture edge copies counter into channel value high/low.
// RL7: capture happens on every qualifying edge regardless of flag.
// RL8: flag set raises interrupt request if enabled, else pollable.
// RL9: captured count written into register two cycles after edge.
// RL10: later capture overwrites earlier value on same channel.
// RL11: reset leaves channel value registers unchanged.
// RL12: counter equal to compare value sets, clears or toggles pin.
// RL13: interrupt request possible on every output compare match.
// RL14: per channel option to toggle pin on counter overflow.
// RL15: stop control halts counting; reset control clears counter, prescaler.
// RL16: unbuffered: software lowers compare value in compare handler.
// RL17: unbuffered: software raises compare value in overflow handler.
// RL18: channel 0 buffer select links channels into one output on pin 0.
// RL19: buffered: channel 0 first, last-written set takes over at overflow.
// RL20: while linked channel 1 control unused, pin 1 released.
// RL21: buffered: software writes only the inactive value set.
// RL22: overflow flag set at modulo value; interrupt if enabled.
// RL23: channel flag set on each capture or compare event.
// RL24: mode pair 0:1 unbuffered compare, 1:0 buffered compare.
// RL25: compare mode edge/level pair 1:0 clears, 1:1 sets output.
// RL26: counter, modulo and channel values exposed as high and low bytes.
`timescale 1ns/1ps
`include "tca_defines.vh"
module tca_timer #(
	parameter CNT_W = `TCA_CNT_W,
	parameter CHANS = 2
) (
	input wire ref_clk,
	input wire rst,
	input wire counter_halt,
	input wire counter_reset,
	input wire [2:0] prescale_select,
	input wire overflow_irq_enable,
	input wire overflow_flag_clear,
	input wire [1:0] mode_sel_b,
	input wire [1:0] mode_sel_a,
	input wire [1:0] edge_level_sel_b,
	input wire [1:0] edge_level_sel_a,
	input wire [1:0] toggle_on_overflow,
	input wire [1:0] chan_irq_enable,
	input wire [1:0] chan_flag_clear,
	input wire [7:0] wr_data,
	input wire modulo_high_wr,
	input wire modulo_low_wr,
	input wire [1:0] chan_value_high_wr,
	input wire [1:0] chan_value_low_wr,
	input wire chan0_pin_in,
	input wire chan1_pin_in,
	output wire chan0_pin_out,
	output wire chan0_pin_oe_n,
	output wire chan1_pin_out,
	output wire chan1_pin_oe_n,
	output wire [7:0] count_high,
	output wire [7:0] count_low,
	output wire [7:0] modulo_high,
	output wire [7:0] modulo_low,
	output wire [7:0] chan0_value_high,
	output wire [7:0] chan0_value_low,
	output wire [7:0] chan1_value_high,
	output wire [7:0] chan1_value_low,
	output wire overflow_flag,
	output wire chan0_event_flag,
	output wire chan1_event_flag,
	output reg overflow_irq,
	output reg [1:0] chan_irq,
	output wire active_set
);

////////////////////////////////////////////////////////////////////////////
// counter and modulo

reg [CNT_W-1:0] cnt_reg;
reg [CNT_W-1:0] cnt_next;
reg [CNT_W-1:0] mod_reg;
reg ovf_flag_reg;
wire ovf_flag_next;
wire tick;
wire at_mod;
wire ovf_evt;
wire linked;
wire [CHANS-1:0] pin_in;
wire [CHANS-1:0] is_capture;
wire [CHANS-1:0] is_compare;
wire [CHANS-1:0] match;
wire [CHANS-1:0] cap_stb;
wire [CHANS-1:0] flag_next;
wire [CNT_W-1:0] cap_val0;
wire [CNT_W-1:0] cap_val1;
wire [CNT_W-1:0] cmp_val0;
wire [CNT_W-1:0] cmp_val1;
reg active_reg;
reg pend_reg;
reg pend_next;

assign pin_in = {chan1_pin_in, chan0_pin_in};

// buffer select of channel 0 outranks its mode_sel_a
assign linked = mode_sel_b[0]; // RL18 RL24

tca_prescale #(
	.DIV_W(`TCA_DIV_W)
) u_prescale (
	.ref_clk(ref_clk),
	.rst(rst),
	.clear(counter_reset),
	.halt(counter_halt),
	.prescale_select(prescale_select),
	.tick(tick)
);

// modulo reset value makes the reset counter free running
assign at_mod = (cnt_reg == mod_reg); // RL1
assign ovf_evt = tick & at_mod & ~counter_reset; // RL22

always @* begin
	cnt_next = cnt_reg;
	if (counter_reset) begin
		cnt_next = `TCA_CNT_RESET; // RL15
	end else if (tick) begin
		if (at_mod) begin
			cnt_next = `TCA_CNT_RESET; // RL1
		end else begin
			cnt_next = cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
		end
	end
end

// reads are plain taps of the flops, so they never disturb counting
always @(posedge ref_clk) begin
	if (rst) begin
		cnt_reg <= `TCA_CNT_RESET;
		mod_reg <= `TCA_MOD_RESET;
	end else begin
		cnt_reg <= cnt_next; // RL2
		if (modulo_high_wr) begin
			mod_reg[15:8] <= wr_data; // RL26
		end
		if (modulo_low_wr) begin
			mod_reg[7:0] <= wr_data; // RL26
		end
	end
end

assign count_high = cnt_reg[15:8]; // RL26
assign count_low = cnt_reg[7:0];
assign modulo_high = mod_reg[15:8];
assign modulo_low = mod_reg[7:0];

// a new overflow in the clearing cycle keeps the flag set
assign ovf_flag_next = ovf_evt | (ovf_flag_reg & ~overflow_flag_clear);

always @(posedge ref_clk) begin
	if (rst) begin
		ovf_flag_reg <= 1'b0;
		overflow_irq <= 1'b0;
	end else begin
		ovf_flag_reg <= ovf_flag_next; // RL22
		overflow_irq <= ovf_flag_next & overflow_irq_enable; // RL22
	end
end

assign overflow_flag = ovf_flag_reg;

////////////////////////////////////////////////////////////////////////////
// buffered compare: which value set drives pin 0

always @* begin
	pend_next = pend_reg;
	if (chan_value_high_wr[1] | chan_value_low_wr[1]) begin
		pend_next = 1'b1; // RL19
	end else if (chan_value_high_wr[0] | chan_value_low_wr[0]) begin
		pend_next = 1'b0; // RL19
	end
end

// switching only at overflow avoids a half-period with mixed values
always @(posedge ref_clk) begin
	if (rst || !linked) begin
		active_reg <= 1'b0; // RL19
		pend_reg <= 1'b0;
	end else begin
		pend_reg <= pend_next;
		if (ovf_evt) begin
			active_reg <= pend_next; // RL19
		end
	end
end

assign active_set = active_reg;

assign cmp_val0 = (linked & active_reg) ? gen_ch[1].val_reg : gen_ch[0].val_reg;
assign cmp_val1 = gen_ch[1].val_reg;

////////////////////////////////////////////////////////////////////////////
// channels

genvar i;
generate
	for (i = 0; i < CHANS; i = i + 1) begin : gen_ch
		reg [CNT_W-1:0] val_reg;
		reg flag_reg;
		reg pin_reg;
		reg oe_n_reg;
		reg pin_next;
		wire [1:0] ms;
		wire [1:0] els;
		wire [CNT_W-1:0] cmp;
		wire [CNT_W-1:0] cap;
		wire unlinked;

		assign ms = {mode_sel_b[i], mode_sel_a[i]};
		assign els = {edge_level_sel_b[i], edge_level_sel_a[i]};
		// channel 1 control is ignored while linked
		assign unlinked = (i == 0) ? 1'b1 : ~linked; // RL20
		assign is_capture[i] = unlinked & ~linked & (ms == `TCA_MS_CAPTURE) |
			(i != 0) & unlinked & (ms == `TCA_MS_CAPTURE); // RL3
		assign is_compare[i] = (i == 0) ?
			(linked | (ms == `TCA_MS_COMPARE)) :
			(unlinked & (ms == `TCA_MS_COMPARE)); // RL3 RL24
		assign cmp = (i == 0) ? cmp_val0 : cmp_val1;
		assign cap = (i == 0) ? cap_val0 : cap_val1;
		assign match[i] = tick & ~counter_reset & is_compare[i] &
			(cnt_next == cmp); // RL12

		// edge seen on stage three, value lands two cycles later
		if (i == 0) begin : gen_cap0
			tca_capture #(
				.CNT_W(CNT_W)
			) u_cap (
				.ref_clk(ref_clk),
				.rst(rst),
				.pin_in(pin_in[i]),
				.capture_en(is_capture[i]),
				.rise_en(edge_level_sel_a[i]),
				.fall_en(edge_level_sel_b[i]),
				.count(cnt_reg),
				.cap_stb(cap_stb[i]),
				.cap_val(cap_val0)
			); // RL9
		end else begin : gen_cap1
			tca_capture #(
				.CNT_W(CNT_W)
			) u_cap (
				.ref_clk(ref_clk),
				.rst(rst),
				.pin_in(pin_in[i]),
				.capture_en(is_capture[i]),
				.rise_en(edge_level_sel_a[i]),
				.fall_en(edge_level_sel_b[i]),
				.count(cnt_reg),
				.cap_stb(cap_stb[i]),
				.cap_val(cap_val1)
			); // RL9
		end

		// capture beats a software write in the same cycle
		always @(posedge ref_clk) begin
			if (cap_stb[i]) begin
				val_reg <= cap; // RL10 RL11
			end else begin
				if (chan_value_high_wr[i]) begin
					val_reg[15:8] <= wr_data; // RL26
				end
				if (chan_value_low_wr[i]) begin
					val_reg[7:0] <= wr_data; // RL26
				end
			end
		end

		assign flag_next[i] = cap_stb[i] | match[i] |
			(flag_reg & ~chan_flag_clear[i]); // RL23

		always @(posedge ref_clk) begin
			if (rst) begin
				flag_reg <= 1'b0;
				chan_irq[i] <= 1'b0;
			end else begin
				flag_reg <= flag_next[i]; // RL23
				chan_irq[i] <= flag_next[i] & chan_irq_enable[i]; // RL8 RL13
			end
		end

		// overflow toggle first, then the compare action of the same tick
		always @* begin
			pin_next = pin_reg;
			if (ovf_evt & toggle_on_overflow[i] & is_compare[i]) begin
				pin_next = ~pin_next; // RL14
			end
			if (match[i]) begin
				if (els == `TCA_ELS_TOGGLE) begin
					pin_next = ~pin_next; // RL12
				end else if (els == `TCA_ELS_CLEAR) begin
					pin_next = 1'b0; // RL25
				end else if (els == `TCA_ELS_SET) begin
					pin_next = 1'b1; // RL25
				end
			end
		end

		always @(posedge ref_clk) begin
			if (rst) begin
				pin_reg <= `TCA_PIN_RESET;
				oe_n_reg <= 1'b1;
			end else begin
				pin_reg <= pin_next;
				// released in capture mode and for pin 1 while linked
				oe_n_reg <= ~(is_compare[i] & (els != `TCA_ELS_NONE)); // RL20
			end
		end
	end
endgenerate

assign chan0_pin_out = gen_ch[0].pin_reg; // RL18
assign chan0_pin_oe_n = gen_ch[0].oe_n_reg;
assign chan1_pin_out = gen_ch[1].pin_reg;
assign chan1_pin_oe_n = gen_ch[1].oe_n_reg;
assign chan0_event_flag = gen_ch[0].flag_reg;
assign chan1_event_flag = gen_ch[1].flag_reg;
assign chan0_value_high = gen_ch[0].val_reg[15:8];
assign chan0_value_low = gen_ch[0].val_reg[7:0];
assign chan1_value_high = gen_ch[1].val_reg[15:8];
assign chan1_value_low = gen_ch[1].val_reg[7:0];

endmodule // tca_timer

// File: verification/tca_timer_assertions.sv
`timescale 1ns/1ps
module tca_timer_chk (
	input wire ref_clk,
	input wire rst,
	input wire counter_halt,
	input wire counter_reset,
	input wire overflow_irq_enable,
	input wire [1:0] mode_sel_b,
	input wire [1:0] mode_sel_a,
	input wire [1:0] edge_level_sel_b,
	input wire [1:0] edge_level_sel_a,
	input wire [1:0] chan_irq_enable,
	input wire chan0_pin_in,
	input wire chan0_pin_out,
	input wire chan1_pin_oe_n,
	input wire [7:0] count_high,
	input wire [7:0] count_low,
	input wire [7:0] chan0_value_high,
	input wire [7:0] chan0_value_low,
	input wire overflow_flag,
	input wire chan0_event_flag,
	input wire overflow_irq,
	input wire [1:0] chan_irq,
	input wire active_set
);
default clocking @(posedge ref_clk); endclocking
default disable iff (rst);
wire [15:0] cnt = {count_high, count_low};
wire [15:0] cv0 = {chan0_value_high, chan0_value_low};
wire cap0 = !mode_sel_a[0] && !mode_sel_b[0];
wire cmp0 = mode_sel_a[0] && !mode_sel_b[0];
////////////////////////////////////////
// three halted samples, so a tick already in flight is not blamed
sequence halted_s;
	(counter_halt && !counter_reset) [*3];
endsequence
sequence rise0_s;
	$rose(chan0_pin_in) && cap0 && edge_level_sel_a[0];
endsequence
sequence hit0_s;
	cmp0 && edge_level_sel_b[0] && $changed(cnt) && cnt == cv0 &&
		!$past(counter_reset);
endsequence
halt_hold_a: assert property (halted_s |-> $stable(cnt))
	else $error("count moved while halted");
creset_zero_a: assert property (counter_reset |=> cnt == 16'h0000)
	else $error("count not cleared");
ovf_irq_a: assert property (overflow_irq ==
	(overflow_flag && $past(overflow_irq_enable)))
	else $error("overflow irq mismatch");
chan_irq_a: assert property (chan_irq[0] ==
	(chan0_event_flag && $past(chan_irq_enable[0])))
	else $error("channel irq mismatch");
ovf_wrap_a: assert property ($rose(overflow_flag) |->
	cnt == 16'h0000 || $past(cnt) == 16'h0000)
	else $error("overflow away from wrap");
cap_lat_a: assert property (rise0_s |-> ##[3:5] chan0_event_flag)
	else $error("capture late");
cmp_set_a: assert property (hit0_s ##0 edge_level_sel_a[0] |->
	chan0_pin_out) else $error("compare did not set");
cmp_clr_a: assert property (hit0_s ##0 !edge_level_sel_a[0] |->
	!chan0_pin_out) else $error("compare did not clear");
link_rel_a: assert property (mode_sel_b[0] && $past(mode_sel_b[0]) |->
	chan1_pin_oe_n) else $error("pin 1 driven while linked");
buf_swap_a: assert property ($changed(active_set) && mode_sel_b[0] &&
	$past(mode_sel_b[0]) |-> cnt == 16'h0000)
	else $error("set swap off overflow");
endmodule // tca_timer_chk
bind tca_timer tca_timer_chk chk (.ref_clk, .rst, .counter_halt,
	.counter_reset, .overflow_irq_enable, .mode_sel_b, .mode_sel_a,
	.edge_level_sel_b, .edge_level_sel_a, .chan_irq_enable, .chan0_pin_in,
	.chan0_pin_out, .chan1_pin_oe_n, .count_high, .count_low,
	.chan0_value_high, .chan0_value_low, .overflow_flag,
	.chan0_event_flag, .overflow_irq, .chan_irq, .active_set);

// File: verification/tca_pin_env.sv
`timescale 1ns/1ps
module tca_pin_env (
	input wire [1:0] ext_level,
	input wire [1:0] ext_drive,
	input wire chan0_pin_out,
	input wire chan0_pin_oe_n,
	input wire chan1_pin_out,
	input wire chan1_pin_oe_n,
	output wire chan0_pin_in,
	output wire chan1_pin_in
);
// nobody driving: the board pull-up wins, never a stale level
assign chan0_pin_in = !chan0_pin_oe_n ? chan0_pin_out :
	ext_drive[0] ? ext_level[0] : 1'b1;
assign chan1_pin_in = !chan1_pin_oe_n ? chan1_pin_out :
	ext_drive[1] ? ext_level[1] : 1'b1;
endmodule // tca_pin_env

// File: verification/testbench.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin \
num_errors++; $display("BAD %s exp %h got %h", n, e, g); end end
module testbench;
reg ref_clk = 0, rst = 1, counter_halt = 0, counter_reset = 0;
reg overflow_irq_enable = 0, overflow_flag_clear = 0;
reg modulo_high_wr = 0, modulo_low_wr = 0;
reg [2:0] prescale_select = 0;
reg [1:0] mode_sel_b = 0, mode_sel_a = 0, edge_level_sel_b = 0;
reg [1:0] edge_level_sel_a = 0, toggle_on_overflow = 0, chan_irq_enable = 0;
reg [1:0] chan_flag_clear = 0, chan_value_high_wr = 0, chan_value_low_wr = 0;
reg [1:0] ext_level = 0, ext_drive = 2'h3;
reg [7:0] wr_data = 0;
reg [15:0] lf = 16'h0003;
wire chan0_pin_in, chan1_pin_in, chan0_pin_out, chan0_pin_oe_n;
wire chan1_pin_out, chan1_pin_oe_n, overflow_flag, chan0_event_flag;
wire chan1_event_flag, overflow_irq, active_set;
wire [1:0] chan_irq;
wire [7:0] count_high, count_low, modulo_high, modulo_low;
wire [7:0] chan0_value_high, chan0_value_low, chan1_value_high;
wire [7:0] chan1_value_low;
wire [15:0] cnt = {count_high, count_low};
wire [31:0] cvs = {chan1_value_high, chan1_value_low, chan0_value_high,
	chan0_value_low};
wire [1:0] flg = {chan1_event_flag, chan0_event_flag};
integer num_errors = 0, n_tests = 0, i, k, a, b, p, d;
tca_timer dut (.ref_clk, .rst, .counter_halt, .counter_reset,
	.prescale_select, .overflow_irq_enable, .overflow_flag_clear,
	.mode_sel_b, .mode_sel_a, .edge_level_sel_b, .edge_level_sel_a,
	.toggle_on_overflow, .chan_irq_enable, .chan_flag_clear, .wr_data,
	.modulo_high_wr, .modulo_low_wr, .chan_value_high_wr,
	.chan_value_low_wr, .chan0_pin_in, .chan1_pin_in, .chan0_pin_out,
	.chan0_pin_oe_n, .chan1_pin_out, .chan1_pin_oe_n, .count_high,
	.count_low, .modulo_high, .modulo_low, .chan0_value_high,
	.chan0_value_low, .chan1_value_high, .chan1_value_low,
	.overflow_flag, .chan0_event_flag, .chan1_event_flag, .overflow_irq,
	.chan_irq, .active_set);
tca_pin_env env (.ext_level, .ext_drive, .chan0_pin_out, .chan0_pin_oe_n,
	.chan1_pin_out, .chan1_pin_oe_n, .chan0_pin_in, .chan1_pin_in);
////////////////////////////////////////
function [15:0] nxt(input [15:0] s);
	nxt = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
endfunction
task cyc(input integer n);
	repeat (n) @(negedge ref_clk);
endtask
// w: 0 modulo, 1 channel 0, 2 channel 1; high byte first
task wr16(input integer w, input [15:0] v);
	integer j;
	for (j = 1; j >= 0; j--) begin
		wr_data = v[8*j +: 8];
		modulo_high_wr = w == 0 && j == 1;
		modulo_low_wr = w == 0 && j == 0;
		chan_value_high_wr = (w > 0 && j == 1) ? w[1:0] : 2'h0;
		chan_value_low_wr = (w > 0 && j == 0) ? w[1:0] : 2'h0;
		cyc(1);
	end
	{modulo_high_wr, modulo_low_wr, chan_value_high_wr} = 4'h0;
	chan_value_low_wr = 2'h0;
endtask
task give_verdict;
	$display("checks %0d mismatches %0d", n_tests, num_errors);
	if (num_errors == 0 && n_tests > 0)
		$display("*** PASS ***");
	else
		$display("*** FAIL ***");
	$finish;
endtask
initial forever #5 ref_clk = !ref_clk;
initial begin
	#300000;
	num_errors++;
	give_verdict;
end
initial begin
	cyc(3);
	`CHK("count", 16'h0000, cnt)
	`CHK("modulo", 16'hffff, {modulo_high, modulo_low})
	`CHK("pins", 2'h3, {chan0_pin_oe_n, chan1_pin_oe_n})
	rst = 0;
	for (i = 0; i < 8; i++) begin
		prescale_select = i;
		counter_reset = 1;
		cyc(1);
		counter_reset = 0;
		k = 1 << (i > 6 ? 6 : i);
		cyc(k + 2);
		a = cnt;
		cyc(4 * k);
		`CHK("rate", a + 4, cnt)
	end
	prescale_select = 0;
	counter_halt = 1;
	cyc(2);
	a = cnt;
	cyc(9);
	`CHK("halt", a, cnt)
	counter_halt = 0;
	counter_reset = 1;
	cyc(1);
	`CHK("clear", 16'h0000, cnt)
	$display("test counter done");
	overflow_irq_enable = 1;
	wr16(0, 16'h0005);
	`CHK("modrd", 16'h0005, {modulo_high, modulo_low})
	counter_reset = 0;
	cyc(3);
	a = cnt;
	cyc(9);
	`CHK("wrap", (a + 9) % 6, cnt)
	`CHK("ovf", 2'h3, {overflow_flag, overflow_irq})
	wr16(0, 16'hffff);
	overflow_flag_clear = 1;
	cyc(1);
	overflow_flag_clear = 0;
	`CHK("ovfclr", 2'h0, {overflow_flag, overflow_irq})
	$display("test modulo done");
	// both channels, every edge choice; flag left set on purpose
	for (i = 0; i < 2; i++) for (k = 1; k < 4; k++) begin
		{edge_level_sel_b[i], edge_level_sel_a[i]} = k;
		chan_flag_clear[i] = 1;
		cyc(8);
		chan_flag_clear[i] = 0;
		// a known old value, far from the coming capture
		wr16(i + 1, cnt ^ 16'h8000);
		p = cvs[16*i +: 16];
		lf = nxt(lf);
		d = 8 + lf[4:0];
		ext_level[i] = 1;
		cyc(8);
		a = cvs[16*i +: 16];
		cyc(d - 8);
		ext_level[i] = 0;
		cyc(8);
		b = cvs[16*i +: 16];
		`CHK("rise", !k[0], a == p)
		`CHK("fall", k == 1, b == a)
		`CHK("flag", 1'b1, flg[i])
		if (k == 3)
			`CHK("gap", d, b - a)
	end
	a = cvs;
	rst = 1;
	cyc(3);
	rst = 0;
	`CHK("keep", a, cvs)
	edge_level_sel_b = 0;
	edge_level_sel_a = 0;
	$display("test capture done");
	mode_sel_a = 2'h3;
	chan_irq_enable = 2'h3;
	p = 0;
	for (k = 3; k > 0; k--) begin
		{edge_level_sel_b[0], edge_level_sel_a[0]} = k;
		{edge_level_sel_b[1], edge_level_sel_a[1]} = k;
		lf = nxt(lf);
		a = 40 + lf[6:0];
		counter_reset = 1;
		chan_flag_clear = 2'h3;
		// values change with the counter held, so no compare is lost
		wr16(1, a);
		wr16(2, a);
		counter_reset = 0;
		chan_flag_clear = 0;
		cyc(a + 4);
		p = k == 3 ? 1 : k == 2 ? 0 : !p;
		`CHK("pin", {2{p[0]}}, {chan1_pin_out, chan0_pin_out})
		`CHK("drv", 2'h0, {chan1_pin_oe_n, chan0_pin_oe_n})
		`CHK("irq", 4'hf, {flg, chan_irq})
	end
	counter_reset = 1;
	wr16(0, 16'h0009);
	wr16(1, 16'h00ff);
	counter_reset = 0;
	toggle_on_overflow = 2'h1;
	cyc(12);
	a = chan0_pin_out;
	cyc(10);
	`CHK("tov", !a[0], chan0_pin_out)
	$display("test compare done");
	mode_sel_b = 2'h1;
	// channel 1 still asks for compare; linking must override it
	mode_sel_a = 2'h2;
	cyc(12);
	`CHK("set0", 1'b0, active_set)
	`CHK("pin1", 1'b1, chan1_pin_oe_n)
	wr16(2, 16'h0004);
	cyc(11);
	`CHK("set1", 1'b1, active_set)
	wr16(1, 16'h0006);
	cyc(11);
	`CHK("back", 1'b0, active_set)
	$display("test buffered done");
	give_verdict;
end
endmodule // testbench
